// ===== yc_sep_defines.svh
// Purpose: shared constants of the y/c separator override control slice
// Assumes: included by bare name from the package and the register module
// Notes: offsets, field positions, reset values, bus addresses and byte length only
//
// Function
// - chroma field picks gain and band-pass
// - clock field picks mode, burst or line lock
// - nonstandard field: adaptive, standard, horizontal nonstandard
// - value 11 forces vertical nonstandard, inter-line comb
// - comb field: adaptive, inter-frame, inter-line
// - killer field: pin plus detect, pin, forced
// - killer active stops chroma subtraction from luma
// - answer at b9h or bbh by select pin
`ifndef YC_SEP_DEFINES_SVH
`define YC_SEP_DEFINES_SVH

// ==========================================================
// register offsets
`define SA_OUTPUT_MODE 8'h00
`define SA_OVERRIDE 8'h01

// ==========================================================
// serial bus write addresses
`define DEV_ADDR_SEL_LOW 8'hb9
`define DEV_ADDR_SEL_HIGH 8'hbb

// ==========================================================
// field positions, register 00 (only bits 3:0 held here)
`define CHROMA_GAIN_BIT 3
`define CHROMA_BPF_BIT 2
`define REG00_SPARE_MSB 1
`define REG00_SPARE_LSB 0

// ==========================================================
// field positions, register 01
`define CLOCK_MSB 7
`define CLOCK_LSB 6
`define NONSTD_MSB 5
`define NONSTD_LSB 4
`define COMB_MSB 3
`define COMB_LSB 2
`define KILLER_MSB 1
`define KILLER_LSB 0

// ==========================================================
// reset values and bus framing
`define REG00_LOW_RESET 4'hf
`define REG01_RESET 8'h00
`define BYTE_BITS 4'h8

`endif

// ===== yc_sep_pkg.sv
// Purpose: types of the y/c separator override control slice
// Assumes: constants come from yc_sep_defines.svh
// Notes: one packed struct carries all state of the top module except the pin synchroniser stages
`include "yc_sep_defines.svh"
`default_nettype none

package yc_sep_pkg;

	// ==========================================================
	// serial slave states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DEV_ADDR,
		ST_ACK_DEV,
		ST_SUB_ADDR,
		ST_ACK_SUB,
		ST_DATA,
		ST_ACK_DATA,
		ST_IGNORE
	} i2c_state_t;

	// ==========================================================
	// effective signal processing kind
	typedef enum logic [1:0] {
		NS_STANDARD,
		NS_HSYNC,
		NS_VSYNC
	} nonstd_mode_t;

	// ==========================================================
	// whole state of the control slice except the pin synchroniser stages
	typedef struct packed {
		i2c_state_t st;        // slave state
		logic [3:0] bitcnt;    // bits shifted in this byte
		logic [7:0] shreg;     // incoming byte
		logic [7:0] subaddr;   // register pointer
		logic scl_d;           // last synced clock level
		logic sda_d;           // last synced data level
		logic sda_drive;       // pulling data low for ack
		logic [3:0] reg00_lo;  // register 00 bits 3:0
		logic [7:0] reg01;     // register 01
		logic gain_one;        // chroma gain 1 when high
		logic bpf_en;          // chroma band-pass on
		logic line_locked;     // line locked clock when high
		nonstd_mode_t nonstd;  // processing kind
		logic inter_line;      // inter-line comb when high
		logic killer;          // killer processing active
	} ctrl_state_t;

endpackage

`default_nettype wire

// ===== yc_sync2.sv
// Purpose: two flip-flop synchroniser for pin levels
// Assumes: inputs are levels from outside the i_mclk domain
// Notes: first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none

module yc_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);

	// ==========================================================
	// width check
	if (WIDTH < 1) begin : g_bad_width
		$error("yc_sync2 width must be at least one");
	end

	logic [WIDTH-1:0] meta; // first stage, feeds second only

	// ==========================================================
	// two stage capture
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			meta <= '1;
			o_sync <= '1;
		end else begin
			meta <= i_async;
			o_sync <= meta;
		end
	end

endmodule

`default_nettype wire

// ===== yc_separator_mode_control_regs.sv
// Purpose: serial-bus write slave and decode of chroma and override fields
// Assumes: 20 mhz i_mclk, sync reset high, bus far slower than clock
// Notes: write only; other sub-addresses are acked and dropped
`timescale 1ns/1ps
`default_nettype none
`include "yc_sep_defines.svh"

module yc_separator_mode_control_regs
	import yc_sep_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_scl,                 // bus clock pin
	input wire logic i_sda,                 // bus data pin level
	output logic o_sda,                     // data drive value, always low
	output logic o_sda_oe,                  // high while pulling data low
	input wire logic i_address_select_pin,  // picks bus address
	input wire logic i_killer_pin,          // external killer request
	input wire logic i_line_pin,            // external line comb request
	input wire logic i_internal_killer_det, // on-chip killer detection
	input wire logic i_motion_det,          // on-chip motion detection
	input wire logic i_nonstd_hsync_det,    // horizontal nonstandard detected
	input wire logic i_nonstd_vsync_det,    // vertical nonstandard detected
	input wire logic i_mode_line_locked,    // operation mode wants line lock
	output logic o_chroma_gain_one,         // gain 1 when high, else 2
	output logic o_chroma_bpf_en,           // band-pass on chroma output
	output logic o_line_locked_clk,         // line lock when high, else burst
	output var nonstd_mode_t o_nonstd_mode, // processing kind
	output logic o_inter_line_comb,         // inter-line when high, else frame
	output logic o_killer_active,           // killer processing on
	output logic o_luma_sub_chroma_en,      // subtract chroma to form luma
	output logic [1:0] o_reg00_spare        // register 00 bits 1:0
);

	// ==========================================================
	// pin synchronisers
	logic [4:0] pins_sync; // scl, sda, select, killer, line
	logic s_scl;
	logic s_sda;
	logic s_asel;
	logic s_kil;
	logic s_line;

	yc_sync2 #(.WIDTH(5)) u_sync (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_async({i_scl, i_sda, i_address_select_pin, i_killer_pin, i_line_pin}),
		.o_sync(pins_sync)
	);

	assign {s_scl, s_sda, s_asel, s_kil, s_line} = pins_sync;

	ctrl_state_t r;      // registered state
	ctrl_state_t next_r; // next state

	// bus events
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic byte_done;
	logic addr_hit;
	logic wr00;
	logic wr01;
	logic [7:0] dev_addr;

	assign scl_rise = s_scl & ~r.scl_d;
	assign scl_fall = ~s_scl & r.scl_d;
	assign bus_start = s_scl & r.scl_d & r.sda_d & ~s_sda;
	assign bus_stop = s_scl & r.scl_d & ~r.sda_d & s_sda;
	assign byte_done = scl_fall & (r.bitcnt == `BYTE_BITS);
	// address chosen by select pin
	assign dev_addr = s_asel ? `DEV_ADDR_SEL_HIGH : `DEV_ADDR_SEL_LOW;
	assign addr_hit = (r.shreg == dev_addr);
	assign wr00 = byte_done && (r.st == ST_DATA) && (r.subaddr == `SA_OUTPUT_MODE);
	assign wr01 = byte_done && (r.st == ST_DATA) && (r.subaddr == `SA_OVERRIDE);

	// ==========================================================
	// next state: bus slave, registers and decode
	always_comb begin
		next_r = r;
		next_r.scl_d = s_scl;
		next_r.sda_d = s_sda;
		// bus framing
		if (bus_stop) begin
			next_r.st = ST_IDLE;
			next_r.sda_drive = 1'b0;
		end else if (bus_start) begin
			next_r.st = ST_DEV_ADDR;
			next_r.bitcnt = 4'h0;
			next_r.sda_drive = 1'b0;
		end else begin
			case (r.st)
				ST_DEV_ADDR, ST_SUB_ADDR, ST_DATA: begin
					// shift on rising clock
					if (scl_rise) begin
						next_r.shreg = {r.shreg[6:0], s_sda};
						next_r.bitcnt = r.bitcnt + 4'h1;
					end
					// whole byte at falling clock
					if (byte_done) begin
						next_r.bitcnt = 4'h0;
						if (r.st == ST_DEV_ADDR) begin
							// ack only our own address
							if (addr_hit) begin
								next_r.st = ST_ACK_DEV;
								next_r.sda_drive = 1'b1;
							end else begin
								next_r.st = ST_IGNORE;
							end
						end else if (r.st == ST_SUB_ADDR) begin
							next_r.subaddr = r.shreg;
							next_r.st = ST_ACK_SUB;
							next_r.sda_drive = 1'b1;
						end else begin
							// data byte, pointer steps on
							next_r.subaddr = r.subaddr + 8'h01;
							next_r.st = ST_ACK_DATA;
							next_r.sda_drive = 1'b1;
						end
					end
				end
				ST_ACK_DEV, ST_ACK_SUB, ST_ACK_DATA: begin
					// release data at end of ack clock
					if (scl_fall) begin
						next_r.sda_drive = 1'b0;
						next_r.st = (r.st == ST_ACK_DEV) ? ST_SUB_ADDR : ST_DATA;
					end
				end
				default: begin
					// idle or ignored transfer waits for framing
					next_r.sda_drive = 1'b0;
				end
			endcase
		end
		// register writes
		if (wr00) begin
			next_r.reg00_lo = r.shreg[3:0];
		end
		if (wr01) begin
			next_r.reg01 = r.shreg;
		end
		// chroma output form
		next_r.gain_one = r.reg00_lo[`CHROMA_GAIN_BIT];
		next_r.bpf_en = r.reg00_lo[`CHROMA_BPF_BIT];
		// clock locking choice
		if (r.reg01[`CLOCK_MSB]) begin
			next_r.line_locked = 1'b1;
		end else if (r.reg01[`CLOCK_LSB]) begin
			next_r.line_locked = 1'b0;
		end else begin
			next_r.line_locked = i_mode_line_locked;
		end
		// standard or nonstandard processing
		case (r.reg01[`NONSTD_MSB:`NONSTD_LSB])
			2'h1: next_r.nonstd = NS_STANDARD;
			2'h2: next_r.nonstd = NS_HSYNC;
			2'h3: next_r.nonstd = NS_VSYNC;
			default: begin
				// adaptive, vertical detection first
				if (i_nonstd_vsync_det) begin
					next_r.nonstd = NS_VSYNC;
				end else if (i_nonstd_hsync_det) begin
					next_r.nonstd = NS_HSYNC;
				end else begin
					next_r.nonstd = NS_STANDARD;
				end
			end
		endcase
		// comb selection, forced vertical nonstandard wins
		if (r.reg01[`NONSTD_MSB:`NONSTD_LSB] == 2'h3) begin
			next_r.inter_line = 1'b1;
		end else if (r.reg01[`COMB_MSB]) begin
			next_r.inter_line = 1'b1;
		end else if (r.reg01[`COMB_LSB]) begin
			next_r.inter_line = s_line;
		end else begin
			next_r.inter_line = s_line | i_motion_det;
		end
		// killer selection
		if (r.reg01[`KILLER_MSB]) begin
			next_r.killer = 1'b1;
		end else if (r.reg01[`KILLER_LSB]) begin
			next_r.killer = s_kil;
		end else begin
			next_r.killer = s_kil | i_internal_killer_det;
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			r <= '0;
			r.st <= ST_IDLE;
			r.scl_d <= 1'b1;
			r.sda_d <= 1'b1;
			r.reg00_lo <= `REG00_LOW_RESET;
			r.reg01 <= `REG01_RESET;
			r.gain_one <= 1'b1;
			r.bpf_en <= 1'b1;
			r.nonstd <= NS_STANDARD;
		end else begin
			r <= next_r;
		end
	end

	// ==========================================================
	// outputs
	assign o_sda = 1'b0;
	assign o_sda_oe = r.sda_drive;
	assign o_chroma_gain_one = r.gain_one;
	assign o_chroma_bpf_en = r.bpf_en;
	assign o_line_locked_clk = r.line_locked;
	assign o_nonstd_mode = r.nonstd;
	assign o_inter_line_comb = r.inter_line;
	assign o_killer_active = r.killer;
	assign o_luma_sub_chroma_en = ~r.killer;
	assign o_reg00_spare = r.reg00_lo[`REG00_SPARE_MSB:`REG00_SPARE_LSB];

	// ==========================================================
	// checks
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	a_chroma_form: assert property (
		wr00 |=> ##1 (o_chroma_gain_one == $past(r.shreg[3], 2))
			&& (o_chroma_bpf_en == $past(r.shreg[2], 2)))
		else $error("chroma output form not taken from write");
	a_clock_force: assert property (
		(r.reg01[7:6] == 2'h1) |=> !o_line_locked_clk)
		else $error("burst lock not forced");
	a_clock_auto: assert property (
		(r.reg01[7:6] == 2'h0) |=> (o_line_locked_clk == $past(i_mode_line_locked)))
		else $error("clock does not follow operation mode");
	a_nonstd_force: assert property (
		(r.reg01[5:4] == 2'h2) |=> (o_nonstd_mode == NS_HSYNC))
		else $error("horizontal nonstandard not forced");
	a_vsync_comb: assert property (
		(r.reg01[5:4] == 2'h3) |=> (o_nonstd_mode == NS_VSYNC) && o_inter_line_comb)
		else $error("vertical nonstandard does not force inter-line");
	a_comb_frame: assert property (
		(r.reg01[5:2] == 4'h1) |=> (o_inter_line_comb == $past(s_line)))
		else $error("inter-frame comb does not follow line pin");
	a_killer_pin: assert property (
		(r.reg01[1:0] == 2'h1) |=> (o_killer_active == $past(s_kil)))
		else $error("killer does not follow pin alone");
	a_killer_sub: assert property (
		o_killer_active |-> !o_luma_sub_chroma_en)
		else $error("chroma subtracted during killer");
	a_addr_ack: assert property (
		(r.st == ST_DEV_ADDR) && byte_done && (r.shreg != dev_addr) |=> !o_sda_oe [*2])
		else $error("foreign address acknowledged");
	a_spare_hold: assert property (
		!wr00 |=> $stable(o_reg00_spare))
		else $error("register 00 low bits changed without write");

	c_write_00: cover property (wr00);
	c_write_01: cover property (wr01);
	c_killer_on: cover property ($rose(o_killer_active));
	c_foreign: cover property ((r.st == ST_IGNORE));

endmodule

`default_nettype wire

// ===== yc_i2c_host.sv
// Purpose: serial control bus host model writing the override registers
// Assumes: data line has a pull-up; clock line idles high between frames
// Notes: signals change on falling i_mclk; q sets quarter bit time
`timescale 1ns/1ps
`default_nettype none

module yc_i2c_host (
	input wire logic i_mclk,
	input wire logic i_sda,     // resolved data line
	output logic o_scl,         // bus clock, still outside frames
	output logic o_sda_low      // high while pulling data low
);
	int q = 6; // quarter bit in clocks; raise for a slow host

	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end

	// ==========================================================
	// timing helper
	task automatic q_wait;
		repeat (q) @(negedge i_mclk);
	endtask

	// one byte msb first, then the ack clock
	task automatic send_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			o_sda_low = ~b[i];
			q_wait;
			o_scl = 1'b1;
			q_wait;
			q_wait;
			o_scl = 1'b0;
			q_wait;
		end
		o_sda_low = 1'b0;
		q_wait;
		o_scl = 1'b1;
		q_wait;
		ack = ~i_sda; // device pulls low to ack
		q_wait;
		o_scl = 1'b0;
		q_wait;
	endtask

	// start, address, sub-address, two data bytes, stop
	task automatic write_regs(input logic [7:0] dev, input logic [7:0] sub,
		input logic [7:0] d0, input logic [7:0] d1, output logic [3:0] acks);
		o_sda_low = 1'b1; // start: data falls, clock high
		q_wait;
		o_scl = 1'b0;
		q_wait;
		send_byte(dev, acks[0]); // caller picks address by select pin
		send_byte(sub, acks[1]);
		send_byte(d0, acks[2]);
		send_byte(d1, acks[3]);
		o_sda_low = 1'b1; // stop: data rises, clock high
		q_wait;
		o_scl = 1'b1;
		q_wait;
		o_sda_low = 1'b0;
		q_wait;
		q_wait;
	endtask
endmodule

`default_nettype wire

// ===== yc_separator_mode_control_regs_tb.sv
// Purpose: self-checking bench of the override control slice
// Assumes: host model on the bus; pins driven on falling clock
// Notes: expected outputs queued by driver, compared by a watcher
`timescale 1ns/1ps
`default_nettype none

module yc_separator_mode_control_regs_tb
	import yc_sep_pkg::*;
;
	logic i_mclk = 1'b0;
	logic i_rst = 1'b1;
	logic [7:0] pins = 8'h00; // kil, line, idet, mot, hs, vs, mode_ll, sel
	logic scl, sda_low, o_sda, o_sda_oe;
	wire logic sda_w;
	wire logic [9:0] got; // packed decoded outputs
	logic [9:0] want; // oldest note taken off the queue
	logic [7:0] rnd0; // random byte for register 00
	logic [7:0] rnd1; // random byte for register 01
	logic [9:0] exp_q[$];
	logic [3:0] r0 = 4'hf; // bench copy of register 00 low
	logic [7:0] r1 = 8'h00; // bench copy of register 01
	int failures = 0;
	int num_checks = 0;

	// ==========================================================
	// clock, wire resolution, instances
	always #25 i_mclk = ~i_mclk;
	assign sda_w = sda_low ? 1'b0 : (o_sda_oe ? o_sda : 1'b1); // pull-up

	yc_i2c_host u_host (.i_mclk(i_mclk), .i_sda(sda_w), .o_scl(scl), .o_sda_low(sda_low));

	yc_separator_mode_control_regs u_dut (
		.i_mclk(i_mclk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda_w),
		.o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_address_select_pin(pins[0]),
		.i_killer_pin(pins[7]), .i_line_pin(pins[6]), .i_internal_killer_det(pins[5]),
		.i_motion_det(pins[4]), .i_nonstd_hsync_det(pins[3]), .i_nonstd_vsync_det(pins[2]),
		.i_mode_line_locked(pins[1]), .o_chroma_gain_one(got[9]), .o_chroma_bpf_en(got[8]),
		.o_line_locked_clk(got[7]), .o_nonstd_mode(got[6:5]), .o_inter_line_comb(got[4]),
		.o_killer_active(got[3]), .o_luma_sub_chroma_en(got[2]), .o_reg00_spare(got[1:0]));

	// ==========================================================
	// expected decode from register copies and pins
	function automatic logic [9:0] model(input logic [3:0] a, input logic [7:0] b,
		input logic [7:0] p);
		logic ll;
		logic [1:0] ns;
		logic il;
		logic k;
		ll = b[7] | (~b[6] & p[1]);
		case (b[5:4])
			2'b00: ns = p[2] ? NS_VSYNC : (p[3] ? NS_HSYNC : NS_STANDARD);
			2'b01: ns = NS_STANDARD;
			2'b10: ns = NS_HSYNC;
			default: ns = NS_VSYNC;
		endcase
		il = (b[5:4] == 2'b11) | b[3] | p[6] | (~b[2] & p[4]);
		k = b[1] | p[7] | (~b[0] & p[5]);
		return {a[3], a[2], ll, ns, il, k, ~k, a[1:0]};
	endfunction

	task automatic check(input logic [9:0] seen, input logic [9:0] want);
		num_checks++;
		if (seen !== want) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, seen, want);
		end
	endtask

	task automatic end_of_test;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// random pins; vsync detect kept low while nonstandard is adaptive
	task automatic new_pins;
		@(negedge i_mclk);
		pins = 8'($urandom());
		if (r1[5:4] == 2'b00) begin
			pins[2] = 1'b0;
		end
	endtask

	// settle, then note the expected outputs
	task automatic expect_now;
		repeat (6) @(negedge i_mclk);
		exp_q.push_back(model(r0, r1, pins));
		repeat (2) @(negedge i_mclk);
	endtask

	// one write frame and its ack pattern
	task automatic frame(input logic [7:0] dev, input logic [7:0] sub, input logic [7:0] d0,
		input logic [7:0] d1, input logic [3:0] want_ack);
		logic [3:0] acks;
		u_host.write_regs(dev, sub, d0, d1, acks);
		check({6'h00, acks}, {6'h00, want_ack});
	endtask

	// ==========================================================
	// watcher: compare oldest note against settled outputs, away from the launching edge
	always @(negedge i_mclk) begin
		if (exp_q.size() > 0) begin
			want = exp_q.pop_front();
			check({8'h00, got[9:8]}, {8'h00, want[9:8]});
			check({9'h000, got[7]}, {9'h000, want[7]});
			check({8'h00, got[6:5]}, {8'h00, want[6:5]});
			check({9'h000, got[4]}, {9'h000, want[4]});
			check({8'h00, got[3:2]}, {8'h00, want[3:2]});
			check({8'h00, got[1:0]}, {8'h00, want[1:0]});
		end
	end

	// watchdog counts as a mismatch
	initial begin
		repeat (80000) @(posedge i_mclk);
		failures++;
		end_of_test;
	end

	// ==========================================================
	// main sequence
	initial begin
		void'($urandom(68277));
		repeat (8) @(posedge i_mclk);
		@(negedge i_mclk) i_rst = 1'b0;
		expect_now; // reset values
		$display("test reset done");
		// every code of every field, two bytes via auto-increment
		for (int v = 0; v < 4; v++) begin
			new_pins;
			frame(pins[0] ? 8'hbb : 8'hb9, 8'h00, {4'h0, 2'(v), ~2'(v)}, {4{2'(v)}}, 4'hf);
			r0 = {2'(v), ~2'(v)};
			r1 = {4{2'(v)}}; // forced modes assumed to match the signal
			expect_now;
		end
		$display("test field codes done");
		// wrong addresses refused, unknown sub-address dropped
		@(negedge i_mclk) pins = 8'h01;
		frame(8'hb9, 8'h00, 8'h00, 8'hff, 4'h0);
		frame(8'h39, 8'h00, 8'h00, 8'hff, 4'h0);
		frame(8'hbb, 8'h05, 8'h55, 8'haa, 4'hf);
		expect_now;
		frame(8'hbb, 8'h01, 8'h96, 8'h3c, 4'hf);
		r1 = 8'h96;
		expect_now;
		$display("test addressing done");
		// random values, prompt and slow host
		for (int i = 0; i < 8; i++) begin
			u_host.q = (i % 2) ? 10 : 6;
			new_pins;
			rnd0 = 8'($urandom());
			rnd1 = 8'($urandom());
			frame(pins[0] ? 8'hbb : 8'hb9, 8'h00, rnd0, rnd1, 4'hf);
			r0 = rnd0[3:0];
			r1 = rnd1;
			expect_now;
			// fresh pin levels under the same register values
			new_pins;
			expect_now;
		end
		$display("test random done");
		end_of_test;
	end
endmodule

`default_nettype wire
